// >>> include/space_page_pkg.sv
/*
 Constants for the space mapping and page select block.
 Assumes offsets are the low eight bits of the configuration space address.
*/
package space_page_pkg;
   // Configuration space offsets
   localparam logic [7:0] off_page_extension = 8'he0;
   localparam logic [7:0] off_space_mapping  = 8'hd2;
   localparam logic [7:0] off_memory_id0     = 8'hf0;
   localparam logic [7:0] off_memory_id1     = 8'hf1;
   localparam logic [7:0] off_power_mode0    = 8'hb0;
   localparam logic [7:0] off_power_mode2    = 8'hb4;
   // Space mapping field positions
   localparam int bit_sram_prog = 0;
   localparam int bit_boot_prog = 1;
   localparam int bit_main_prog = 2;
   localparam int bit_boot_data = 3;
   localparam int bit_main_data = 4;
   // Power mode register 0 field position
   localparam int bit_fast_response = 3;
   // Reset values
   localparam logic [7:0] reset_page        = 8'h00;
   localparam logic [7:0] reset_power_mode0 = 8'h08;
   localparam logic [7:0] reset_power_mode2 = 8'h00;
   localparam logic [7:0] read_unmapped     = 8'h00;
   // Widths
   localparam int addr_width  = 20;
   localparam int array_width = 82;
   localparam int ctrl_width  = 5;
   localparam int pin_width   = 71;
   // Standby timing
   localparam int clk_period_ps   = 8000;
   localparam int standby_time_ps = 70000;
   localparam int standby_cycles  =
      (standby_time_ps + clk_period_ps - 1) / clk_period_ps;
   localparam logic [3:0] standby_count =
      4'(standby_cycles);
   // Bus states
   typedef enum logic [2:0] {
      st_idle  = 3'b001,
      st_write = 3'b010,
      st_read  = 3'b100
   } bus_state_t;
endpackage

// >>> verilog/space_page_select.sv
/*
 Memory space mapping, page register, identification registers, power
 controls and logic array input bus composition.
 Assumes MCU pins are asynchronous to clk_sys and that decoded selects
 arrive from the decode array on clk_sys.
*/
`timescale 1ns/10ps
module space_page_select
   import space_page_pkg::*;
#(
   parameter logic [7:0] space_mapping_init = 8'h0c,
   parameter logic [7:0] memory_id0_value   = 8'h5a, // Arbitrary value
   parameter logic [7:0] memory_id1_value   = 8'ha5  // Arbitrary value
) (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   // MCU bus pins
   input  wire logic [addr_width-1:0] mcu_addr,
   input  wire logic [7:0]            data_in,
   output logic      [7:0]            data_out,
   output logic                       data_oe,
   input  wire logic                  write_strobe_n,
   input  wire logic                  read_strobe_n,
   input  wire logic                  program_fetch_strobe_n,
   input  wire logic                  addr_latch_enable,
   input  wire logic                  byte_enable_n,
   input  wire logic                  extended_mode,
   input  wire logic                  power_down_term,
   // Port pins feeding the arrays
   input  wire logic [23:0]           input_cell,
   input  wire logic [3:0]            port_d_in,
   input  wire logic [7:0]            port_f_in,
   // Internal sources
   input  wire logic                  config_space_base,
   input  wire logic [7:0]            main_sector_selects,
   input  wire logic [3:0]            boot_sector_selects,
   input  wire logic                  sram_select,
   input  wire logic                  io_select,
   input  wire logic [7:0]            cell_group_a_feedback,
   input  wire logic [7:0]            cell_group_b_feedback,
   input  wire logic                  boot_ready_busy,
   input  wire logic [2:0]            chip_select_terms,
   // Outputs to memories and arrays
   output logic      [7:0]            main_sector_enable,
   output logic      [3:0]            boot_sector_enable,
   output logic                       sram_enable,
   output logic                       io_enable,
   output logic      [7:0]            page_bits,
   output logic      [7:0]            general_page_bits,
   output logic      [array_width-1:0] array_input_bus,
   output logic      [ctrl_width-1:0] gated_mcu_ctrl,
   output logic                       array_standby,
   output logic      [2:0]            external_chip_selects
);

   // Pin levels while idle, so no false strobe edge follows reset
   localparam logic [pin_width-1:0] pin_idle = {{addr_width{1'h0}},
      8'h00, 3'h7, 1'h0, 1'h1, 1'h0, 1'h0, 24'h000000, 4'h0, 8'h00};

   // Two-flop synchroniser for every asynchronous pin
   logic [pin_width-1:0] pin_meta;
   logic [pin_width-1:0] pin_sync;
   wire  [pin_width-1:0] pin_raw = {mcu_addr, data_in, write_strobe_n,
      read_strobe_n, program_fetch_strobe_n, addr_latch_enable,
      byte_enable_n, extended_mode, power_down_term, input_cell,
      port_d_in, port_f_in};

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pin_meta <= pin_idle;
         pin_sync <= pin_idle;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // Synchronised pin fields
   wire [addr_width-1:0] s_addr  = pin_sync[70:51];
   wire [7:0]            s_data  = pin_sync[50:43];
   wire                  s_wr_n  = pin_sync[42];
   wire                  s_rd_n  = pin_sync[41];
   wire                  s_pf_n  = pin_sync[40];
   wire                  s_ale   = pin_sync[39];
   wire                  s_be_n  = pin_sync[38];
   wire                  s_ext   = pin_sync[37];
   wire                  s_pdn   = pin_sync[36];
   wire [23:0]           s_cells = pin_sync[35:12];
   wire [3:0]            s_pd    = pin_sync[11:8];
   wire [7:0]            s_pf    = pin_sync[7:0];

   function automatic logic offset_hit(input logic [addr_width-1:0] a,
                                       input logic [7:0] off);
      offset_hit = (a[7:0] == off);
   endfunction

   function automatic logic space_ok(input logic prog, input logic data,
                                     input logic prog_en,
                                     input logic data_en);
      space_ok = (prog && prog_en) || (data && data_en);
   endfunction

   // Registers
   logic [7:0] page_extension;
   logic [7:0] space_mapping;
   logic [7:0] power_mode_reg0;
   logic [7:0] power_mode_reg2;
   logic       wr_n_last;
   bus_state_t bus_state;
   bus_state_t next_bus_state;

   // Config select delayed to line up with the synchronised pins
   logic [1:0] base_delay;
   wire        base_aligned = base_delay[1];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         base_delay <= 2'h0;
      end else begin
         base_delay <= {base_delay[0], config_space_base};
      end
   end

   // Register write on trailing edge of the write strobe
   wire wr_trail = s_wr_n && !wr_n_last && base_aligned;
   wire wr_page  = wr_trail && offset_hit(s_addr, off_page_extension);
   wire wr_map   = wr_trail && offset_hit(s_addr, off_space_mapping);
   wire wr_pm0   = wr_trail && offset_hit(s_addr, off_power_mode0);
   wire wr_pm2   = wr_trail && offset_hit(s_addr, off_power_mode2);
   wire rd_cfg   = !s_rd_n && base_aligned;

   always_comb begin
      next_bus_state = st_idle;
      case (bus_state)
         st_idle:  begin
            if (!s_wr_n && base_aligned)
               next_bus_state = st_write;
            else if (rd_cfg)
               next_bus_state = st_read;
         end
         st_write: next_bus_state = s_wr_n ? st_idle : st_write;
         st_read:  next_bus_state = rd_cfg ? st_read : st_idle;
         default:  next_bus_state = st_idle;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus_state <= st_idle;
         wr_n_last <= 1'b1;
      end else begin
         bus_state <= next_bus_state;
         wr_n_last <= s_wr_n;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         page_extension  <= reset_page;
         space_mapping   <= space_mapping_init;
         power_mode_reg0 <= reset_power_mode0;
         power_mode_reg2 <= reset_power_mode2;
      end else begin
         if (wr_page)
            page_extension <= s_data;
         if (wr_map)
            space_mapping <= s_data;
         if (wr_pm0)
            power_mode_reg0 <= s_data;
         if (wr_pm2)
            power_mode_reg2 <= s_data;
      end
   end

   // Read data mux
   logic [7:0] read_value;
   always_comb begin
      read_value = read_unmapped;
      if (offset_hit(s_addr, off_page_extension))
         read_value = page_extension;
      else if (offset_hit(s_addr, off_space_mapping))
         read_value = space_mapping;
      else if (offset_hit(s_addr, off_memory_id0))
         read_value = memory_id0_value;
      else if (offset_hit(s_addr, off_memory_id1))
         read_value = memory_id1_value;
      else if (offset_hit(s_addr, off_power_mode0))
         read_value = power_mode_reg0;
      else if (offset_hit(s_addr, off_power_mode2))
         read_value = power_mode_reg2;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         data_out <= read_unmapped;
         data_oe  <= 1'b0;
      end else begin
         data_out <= read_value;
         data_oe  <= (next_bus_state == st_read);
      end
   end

   // Strobe space qualification and select priority
   wire is_prog  = !s_pf_n;
   wire is_data  = !s_rd_n;
   wire boot_any = |boot_sector_selects;
   wire high_pri = sram_select || io_select;
   wire main_ok  = space_ok(is_prog, is_data,
      space_mapping[bit_main_prog], space_mapping[bit_main_data]);
   wire boot_ok  = space_ok(is_prog, is_data,
      space_mapping[bit_boot_prog], space_mapping[bit_boot_data]);
   wire sram_ok  = space_ok(is_prog, is_data,
      space_mapping[bit_sram_prog], 1'b1);
   wire [7:0] next_main = (main_sector_selects & {8{main_ok}}) &
      {8{!boot_any && !high_pri}};
   wire [3:0] next_boot = (boot_sector_selects & {4{boot_ok}}) &
      {4{!high_pri}};

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         main_sector_enable <= '0;
         boot_sector_enable <= '0;
         sram_enable        <= 1'b0;
         io_enable          <= 1'b0;
      end else begin
         main_sector_enable <= next_main;
         boot_sector_enable <= next_boot;
         sram_enable        <= sram_select && sram_ok;
         io_enable          <= io_select && is_data;
      end
   end

   // Page bits to both arrays
   assign page_bits         = page_extension;
   assign general_page_bits = page_extension;

   // Control signals with power blocking
   wire [ctrl_width-1:0] raw_ctrl = {s_be_n, s_ale, s_pf_n, s_rd_n,
      s_wr_n};
   wire [ctrl_width-1:0] next_ctrl = raw_ctrl &
      ~power_mode_reg2[ctrl_width-1:0];

   // Address selection by processor mode
   wire [15:0] array_addr = s_ext ? s_addr[19:4] : s_addr[15:0];

   // Array input bus composition
   wire [array_width-1:0] next_bus = {array_addr, next_ctrl[2:0], reset,
      s_pdn, s_cells, s_pd, s_pf, page_extension, cell_group_a_feedback,
      cell_group_b_feedback, boot_ready_busy};

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         array_input_bus       <= '0;
         gated_mcu_ctrl        <= '0;
         external_chip_selects <= '0;
      end else begin
         array_input_bus       <= next_bus;
         gated_mcu_ctrl        <= next_ctrl;
         external_chip_selects <= chip_select_terms;
      end
   end

   // Standby after the array inputs stay unchanged
   logic [3:0] idle_count;
   wire inputs_moved = (next_bus != array_input_bus);
   wire fast_mode    = power_mode_reg0[bit_fast_response];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         idle_count    <= '0;
         array_standby <= 1'b0;
      end else begin
         if (inputs_moved || fast_mode)
            idle_count <= '0;
         else if (idle_count != standby_count)
            idle_count <= idle_count + 4'h1;
         array_standby <= !fast_mode && !inputs_moved &&
            (idle_count == standby_count);
      end
   end

endmodule

// >>> test/space_page_select_monitor.sv
/* Port checker for the space mapping and page select block.
 Assumes it is bound to space_page_select and sees only its ports. */
`timescale 1ns/10ps
module space_page_select_monitor (
   // Clock, reset and MCU pins
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        read_strobe_n,
   input wire logic        program_fetch_strobe_n,
   input wire logic        data_oe,
   // Selects and enables
   input wire logic        sram_select,
   input wire logic        io_select,
   input wire logic [2:0]  chip_select_terms,
   input wire logic [2:0]  external_chip_selects,
   input wire logic [7:0]  main_sector_enable,
   input wire logic [3:0]  boot_sector_enable,
   input wire logic        sram_enable,
   input wire logic        io_enable,
   // Array side
   input wire logic [7:0]  page_bits,
   input wire logic [7:0]  general_page_bits,
   input wire logic [81:0] array_input_bus,
   input wire logic        array_standby
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   page_mirror_a: assert property (general_page_bits == page_bits)
      else $error("spare page bits differ");
   page_feed_a: assert property ($stable(page_bits) |->
      array_input_bus[24:17] == page_bits) else $error("page not on bus");
   ecs_follow_a: assert property (!$past(reset) |->
      external_chip_selects == $past(chip_select_terms))
      else $error("chip selects lag");
   sram_first_a: assert property (sram_enable || io_enable |->
      main_sector_enable == 8'h00 && boot_sector_enable == 4'h0)
      else $error("flash beat sram or io");
   boot_first_a: assert property (|boot_sector_enable |->
      main_sector_enable == 8'h00) else $error("main beat boot");
   sram_cause_a: assert property (sram_enable |-> $past(sram_select))
      else $error("sram enable without select");
   io_cause_a: assert property (io_enable |->
      $past(io_select) && !$past(read_strobe_n, 3))
      else $error("io enable without data read");
   main_cause_a: assert property (|main_sector_enable |->
      !$past(read_strobe_n, 3) || !$past(program_fetch_strobe_n, 3))
      else $error("main enable without strobe");
   oe_cause_a: assert property (data_oe |-> !$past(read_strobe_n, 3))
      else $error("read data without strobe");
   idle_standby_a: assert property (array_standby |->
      $past(array_input_bus) == $past(array_input_bus, 2))
      else $error("standby while inputs move");
endmodule
bind space_page_select space_page_select_monitor u_mon (.*);

// >>> test/mcu_bus_model.sv
/* MCU bus model: register writes, reads and memory strobes.
 Assumes the block samples its pins through two-flop synchronisers. */
`timescale 1ns/10ps
module mcu_bus_model (
   // Clock and read data
   input  wire logic        clk_sys,
   input  wire logic [7:0]  data_out,
   // Bus pins
   output logic      [19:0] mcu_addr,
   output logic      [7:0]  data_in,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             program_fetch_strobe_n,
   output logic             config_space_base
);
   logic [7:0] rd_val;
   event       rd_done;
   event       st_done;
   initial begin
      {mcu_addr, data_in, config_space_base} = 29'h0;
      {write_strobe_n, read_strobe_n, program_fetch_strobe_n} = 3'b111;
   end
   task automatic park(input logic [19:0] a);
      @(posedge clk_sys);
      mcu_addr <= a;
   endtask
   // Write, strobe low three cycles then high three
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      mcu_addr <= {12'h000, a};
      data_in <= d;
      config_space_base <= 1'b1;
      write_strobe_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      write_strobe_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      config_space_base <= 1'b0;
      data_in <= ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      mcu_addr <= {12'h000, a};
      config_space_base <= 1'b1;
      read_strobe_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_val = data_out;
      ->rd_done;
      read_strobe_n <= 1'b1;
      config_space_base <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // Memory access by data read or program fetch
   task automatic strobe(input logic d);
      @(posedge clk_sys);
      if (d) read_strobe_n <= 1'b0;
      else program_fetch_strobe_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      ->st_done;
      read_strobe_n <= 1'b1;
      program_fetch_strobe_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
endmodule

// >>> test/memory_space_and_page_select_tb.sv
/* Self-checking bench for space_page_select.
 Assumes the MCU bus model and the bound port checker. */
`timescale 1ns/10ps
module memory_space_and_page_select_tb;
   logic        clk_sys, reset, data_oe, write_strobe_n, read_strobe_n;
   logic        program_fetch_strobe_n, addr_latch_enable, byte_enable_n;
   logic        extended_mode, power_down_term, config_space_base;
   logic        sram_select, io_select, boot_ready_busy, sram_enable;
   logic        io_enable, array_standby;
   logic [19:0] mcu_addr;
   logic [7:0]  data_in, data_out, port_f_in, main_sector_selects;
   logic [7:0]  cell_group_a_feedback, cell_group_b_feedback;
   logic [7:0]  main_sector_enable, page_bits, general_page_bits;
   logic [23:0] input_cell;
   logic [3:0]  port_d_in, boot_sector_selects, boot_sector_enable;
   logic [2:0]  chip_select_terms, external_chip_selects;
   logic [4:0]  gated_mcu_ctrl;
   logic [81:0] array_input_bus;
   logic [7:0]  exp_q [$];
   int          miscompares = 0;
   int          comparisons = 0;
   localparam logic [7:0] offs [7] = '{8'he0, 8'hd2, 8'hf0, 8'hf1,
                                       8'hb0, 8'hb4, 8'h33};
   localparam logic [7:0] rvals [7] = '{8'h00, 8'h0c, 8'h5a, 8'ha5,
                                        8'h08, 8'h00, 8'h00};
   localparam logic [7:0] maps [4] = '{8'h0c, 8'h14, 8'h04, 8'h1a};
   space_page_select u_dut (.*);
   mcu_bus_model m (.*);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [81:0] g, input logic [81:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   always @(m.rd_done) begin
      chk(82'(m.rd_val), 82'(exp_q.pop_front()));
      chk(82'(data_oe), 82'(1'b1));
   end
   always @(m.st_done) begin
      chk(82'({|main_sector_enable, |boot_sector_enable, sram_enable,
         io_enable}), 82'(exp_q.pop_front()));
   end
   task automatic acc(input logic [3:0] s, input logic d, input logic [3:0] e);
      @(posedge clk_sys);
      main_sector_selects <= 8'(s[3]) << $urandom_range(7);
      boot_sector_selects <= 4'(s[2]) << $urandom_range(3);
      sram_select <= s[1];
      io_select <= s[0];
      exp_q.push_back({4'h0, e});
      m.strobe(d);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      logic [7:0]  v;
      logic [3:0]  on;
      logic [65:0] w;
      void'($urandom(65262));
      {reset, byte_enable_n} = 2'b11;
      {addr_latch_enable, extended_mode, power_down_term} = 3'h0;
      {sram_select, io_select, boot_ready_busy, port_f_in} = 11'h0;
      {main_sector_selects, boot_sector_selects, input_cell} = 36'h0;
      {cell_group_a_feedback, cell_group_b_feedback, port_d_in} = 20'h0;
      chip_select_terms = 3'h0;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 7; i++) begin
         exp_q.push_back(rvals[i]);
         m.rd(offs[i]);
      end
      $display("reset values done");
      v = 8'($urandom);
      m.wr(8'he0, v);
      m.wr(8'hf1, ~v);
      exp_q.push_back(v);
      m.rd(8'he0);
      exp_q.push_back(8'ha5);
      m.rd(8'hf1);
      chk(82'(general_page_bits), 82'(v));
      chk(82'(array_input_bus[24:17]), 82'(v));
      $display("page register done");
      for (int x = 0; x < 2; x++) begin
         m.park(20'($urandom));
         @(posedge clk_sys);
         extended_mode <= x[0];
         input_cell <= 24'($urandom);
         {port_d_in, port_f_in, cell_group_a_feedback} <= 20'($urandom);
         {cell_group_b_feedback, boot_ready_busy, power_down_term,
            chip_select_terms} <= 13'($urandom);
         repeat (7) @(posedge clk_sys);
         w = {3'b111, 1'b0, power_down_term, input_cell, port_d_in, port_f_in,
            v, cell_group_a_feedback, cell_group_b_feedback,
            boot_ready_busy};
         chk(82'(array_input_bus[65:0]), 82'(w));
         chk(82'(array_input_bus[81:66]),
            82'(x ? mcu_addr[19:4] : mcu_addr[15:0]));
         chk(82'(external_chip_selects), 82'(chip_select_terms));
         chk(82'(data_oe), 82'(1'b0));
      end
      $display("array bus done");
      m.wr(8'hb0, 8'h00);
      repeat (16) @(posedge clk_sys);
      chk(82'(array_standby), 82'(1'b1));
      input_cell <= ~input_cell;
      repeat (6) @(posedge clk_sys);
      chk(82'(array_standby), 82'(1'b0));
      m.wr(8'hb0, 8'h08);
      repeat (16) @(posedge clk_sys);
      chk(82'(array_standby), 82'(1'b0));
      addr_latch_enable <= 1'b1;
      byte_enable_n <= 1'b0;
      m.wr(8'hb4, 8'h1f);
      repeat (5) @(posedge clk_sys);
      chk(82'({gated_mcu_ctrl, array_input_bus[65:63]}), 82'(0));
      m.wr(8'hb4, 8'h00);
      repeat (5) @(posedge clk_sys);
      chk(82'(gated_mcu_ctrl), 82'(5'h0f));
      $display("power controls done");
      for (int i = 0; i < 4; i++) begin
         m.wr(8'hd2, maps[i]);
         for (int d = 0; d < 2; d++) begin
            on = d ? {maps[i][4], maps[i][3], 2'b11}
                   : {maps[i][2], maps[i][1], maps[i][0], 1'b0};
            for (int k = 0; k < 4; k++)
               acc(4'h8 >> k, d[0], on & (4'h8 >> k));
         end
      end
      m.wr(8'hd2, 8'h1f);
      acc(4'b1110, 1'b1, 4'b0010);
      acc(4'b1100, 1'b0, 4'b0100);
      acc(4'b1001, 1'b1, 4'b0001);
      acc(4'b0000, 1'b1, 4'b0000);
      $display("space mapping done");
      tally_and_finish;
   end
endmodule
